/* File: hw/uart_ctrl_regs.svh */
`ifndef UART_CTRL_REGS_SVH
`define UART_CTRL_REGS_SVH

`define OFS_DATA      3'h0
`define OFS_IER       3'h1
`define OFS_ISR_FCR   3'h2
`define OFS_FEAT      3'h3
`define OFS_TXCNT     3'h4
`define OFS_RXCNT     3'h5
`define OFS_LSR       3'h6
`define OFS_MSR       3'h7

`define CODE_NONE     6'h01
`define CODE_RLS      6'h06
`define CODE_RDA      6'h04
`define CODE_CTI      6'h0C
`define CODE_THRE     6'h02
`define CODE_MSI      6'h00
`define CODE_XOFF     6'h10
`define CODE_FC       6'h20

`define FCR_EN        0
`define FCR_RXRST     1
`define FCR_TXRST     2
`define FCR_DMA       3
`define FEAT_256      0
`define FEAT_ENH      4
`define FEAT_ARTS     6
`define FEAT_ACTS     7
`define IER_RDA       0
`define IER_THRE      1
`define IER_RLS       2
`define IER_MSI       3
`define IER_XOFF      5
`define IER_RTS       6
`define IER_CTS       7
`define IER_RST       8'h00

`define TRIG_8        9'h008
`define TRIG_16       9'h010
`define TRIG_32       9'h020
`define TRIG_56       9'h038
`define TRIG_60       9'h03C
`define SMALL_DEPTH   9'h040
`define CHAR_TIMEOUT  3'h4
`endif

/* File: hw/uart_ctrl_pkg.sv */
package uart_ctrl_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic carrier_detect_n;
    logic ring_indicator_n;
    logic dsr_n;
    logic cts_n;
  } modem_pins_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       fifo_en;
    logic       mode256;
    logic       enh_en;
    logic       auto_rts;
    logic       auto_cts;
    logic       dma_mode;
    logic [1:0] rx_sel;
    logic [1:0] tx_sel;
    logic [7:0] ier;
    logic       rls;
    logic       cti;
    logic       thre;
    logic       msi;
    logic       xoff;
    logic       fcev;
    logic [2:0] to_cnt;
    logic [3:0] m_s1;
    logic [3:0] m_s2;
    logic [3:0] m_s3;
    logic [3:0] m_st;
    logic [3:0] m_dlt;
    logic       rts_prev;
    logic       tx_above;
    logic       tx_busy;
  } ctrl_state_t;
endpackage

/* File: hw/char_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_regs.svh"
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             fifo_en,
  input  wire logic             big,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rdata,
  output logic      [AW:0]      count,
  output logic                  full,
  output logic                  empty
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s_q, s_d;
  logic [AW:0] cap;
  logic        do_push, do_pop;

  if (DEPTH < 64 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two, 64 or more");
  end

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p, input logic [AW:0] c);
    nxt = ({1'b0, p} + 1'b1 >= c) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    cap = !fifo_en ? (AW+1)'(1) : big ? (AW+1)'(DEPTH) : (AW+1)'(`SMALL_DEPTH);
    full    = s_q.cnt >= cap;
    empty   = s_q.cnt == '0;
    do_push = push && !full;
    do_pop  = pop && !empty;
    s_d     = s_q;
    if (do_push) begin
      s_d.mem[s_q.wp] = wdata;
      s_d.wp          = nxt(s_q.wp, cap);
    end
    if (do_pop) begin
      s_d.rp = nxt(s_q.rp, cap);
    end
    unique case ({do_push, do_pop})
      2'b10:   s_d.cnt = s_q.cnt + 1'b1;
      2'b01:   s_d.cnt = s_q.cnt - 1'b1;
      default: s_d.cnt = s_q.cnt;
    endcase
    if (!fifo_en) begin
      s_d.wp = '0;
      s_d.rp = '0;
    end
    if (clr) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end
  end

  assign rdata = s_q.mem[s_q.rp];
  assign count = s_q.cnt;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

/* File: hw/irq_prio.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_regs.svh"
module irq_prio (
  input  wire logic [6:0] pend,
  output logic      [5:0] code
);
  function automatic logic [5:0] code_of(input int i);
    unique case (i)
      0:       code_of = `CODE_RLS;
      1:       code_of = `CODE_RDA;
      2:       code_of = `CODE_CTI;
      3:       code_of = `CODE_THRE;
      4:       code_of = `CODE_MSI;
      5:       code_of = `CODE_XOFF;
      default: code_of = `CODE_FC;
    endcase
  endfunction

  always_comb begin
    code = `CODE_NONE;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        code = code_of(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/uart_irq_priority_fifo_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_regs.svh"
module uart_irq_priority_fifo_ctrl #(
  parameter int FIFO_DEPTH = 256,
  parameter int CW         = $clog2(FIFO_DEPTH) + 1
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire uart_ctrl_pkg::reg_req_t    reg_req,
  output logic      [7:0]                 reg_rdata,
  input  wire logic                       rx_push,
  input  wire logic [7:0]                 rx_data,
  input  wire logic                       lsr_err_event,
  input  wire logic [7:0]                 line_status_reg,
  input  wire logic                       xoff_event,
  input  wire logic                       char_tick,
  input  wire uart_ctrl_pkg::modem_pins_t modem_pins,
  input  wire logic                       rts_n,
  input  wire logic                       tx_pop,
  output logic      [7:0]                 tx_data,
  output logic                            tx_empty,
  output logic                            dma_mode,
  output logic                            irq
);
  import uart_ctrl_pkg::*;

  ctrl_state_t   s_q, s_d;
  logic [CW-1:0] tx_cnt, rx_cnt, rx_trig, tx_trig;
  logic          tx_full, rx_full, rx_empty;
  logic [7:0]    rx_q, isr_val, rd_val;
  logic [5:0]    code;
  logic [6:0]    pend;
  logic          wr_data, rd_data, wr_fcr, rd_isr, rd_lsr, rd_msr, wr_ier, wr_feat;
  logic          tx_clr, rx_clr, rda, modem_chg, fc_rise, thre_evt, tx_above_now;
  logic [3:0]    m_new;

  // counts read back through 8 bits and a count width of log2 of depth plus one
  if (FIFO_DEPTH < 64 || FIFO_DEPTH > 256 || CW != $clog2(FIFO_DEPTH) + 1) begin : g_depth_chk
    $error("fifo depth must lie between 64 and 256");
  end

  function automatic logic [8:0] trig_level(input logic [1:0] sel, input logic rx);
    unique case (sel)
      2'b00: trig_level = `TRIG_8;
      2'b01: trig_level = `TRIG_16;
      2'b10: trig_level = rx ? `TRIG_56 : `TRIG_32;
      2'b11: trig_level = rx ? `TRIG_60 : `TRIG_56;
    endcase
  endfunction

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  assign wr_data = reg_req.wr && reg_req.addr == `OFS_DATA;
  assign rd_data = reg_req.rd && reg_req.addr == `OFS_DATA;
  assign wr_ier  = reg_req.wr && reg_req.addr == `OFS_IER;
  assign wr_fcr  = reg_req.wr && reg_req.addr == `OFS_ISR_FCR;
  assign rd_isr  = reg_req.rd && reg_req.addr == `OFS_ISR_FCR;
  assign wr_feat = reg_req.wr && reg_req.addr == `OFS_FEAT;
  assign rd_lsr  = reg_req.rd && reg_req.addr == `OFS_LSR;
  assign rd_msr  = reg_req.rd && reg_req.addr == `OFS_MSR;

  assign tx_clr = (wr_fcr && (reg_req.wdata[`FCR_TXRST]
                  || reg_req.wdata[`FCR_EN] != s_q.fifo_en))
                  || (wr_feat && reg_req.wdata[`FEAT_256] != s_q.mode256);
  assign rx_clr = (wr_fcr && (reg_req.wdata[`FCR_RXRST]
                  || reg_req.wdata[`FCR_EN] != s_q.fifo_en))
                  || (wr_feat && reg_req.wdata[`FEAT_256] != s_q.mode256);

  // ------------------------------------------------------------
  // fifos
  // ------------------------------------------------------------
  char_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .clr     (tx_clr),
    .fifo_en (s_q.fifo_en),
    .big     (s_q.mode256),
    .push    (wr_data),
    .wdata   (reg_req.wdata),
    .pop     (tx_pop),
    .rdata   (tx_data),
    .count   (tx_cnt),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  char_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .clr     (rx_clr),
    .fifo_en (s_q.fifo_en),
    .big     (s_q.mode256),
    .push    (rx_push),
    .wdata   (rx_data),
    .pop     (rd_data),
    .rdata   (rx_q),
    .count   (rx_cnt),
    .full    (rx_full),
    .empty   (rx_empty)
  );

  // ------------------------------------------------------------
  // interrupt sources and priority
  // ------------------------------------------------------------
  // rx and tx trigger decode
  assign rx_trig = CW'(trig_level(s_q.rx_sel, 1'b1));
  assign tx_trig = CW'(trig_level(s_q.tx_sel, 1'b0));

  assign rda = s_q.fifo_en ? (rx_cnt >= rx_trig) : !rx_empty;

  assign tx_above_now = tx_cnt > tx_trig;
  assign thre_evt     = s_q.fifo_en ? (s_q.tx_above && !tx_above_now)
                                    : (s_q.tx_busy && tx_empty);

  assign pend = {s_q.fcev && (s_q.ier[`IER_RTS] || s_q.ier[`IER_CTS]),
                 s_q.xoff && s_q.ier[`IER_XOFF],
                 s_q.msi  && s_q.ier[`IER_MSI],
                 s_q.thre && s_q.ier[`IER_THRE],
                 s_q.cti  && s_q.ier[`IER_RDA],
                 rda      && s_q.ier[`IER_RDA],
                 s_q.rls  && s_q.ier[`IER_RLS]};

  irq_prio u_prio (
    .pend (pend),
    .code (code)
  );

  assign irq = pend != '0;

  // 256 mode: tx not-full bit, rx full bit; otherwise both bits show fifo enable
  assign isr_val = {s_q.mode256 ? !tx_full : s_q.fifo_en,
                    s_q.mode256 ? rx_full : s_q.fifo_en,
                    code};

  always_comb begin
    unique case (reg_req.addr)
      `OFS_DATA:    rd_val = rx_q;
      `OFS_IER:     rd_val = s_q.ier;
      `OFS_ISR_FCR: rd_val = isr_val;
      `OFS_FEAT:    rd_val = {s_q.auto_cts, s_q.auto_rts, 1'b0, s_q.enh_en, 3'b000,
                              s_q.mode256};
      `OFS_TXCNT:   rd_val = 8'(tx_cnt);
      `OFS_RXCNT:   rd_val = 8'(rx_cnt);
      `OFS_LSR:     rd_val = line_status_reg;
      `OFS_MSR:     rd_val = {~s_q.m_st, s_q.m_dlt};
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    s_d.rdata = reg_req.rd ? rd_val : 8'h00;

    // modem pin synchroniser, change taken when stages 2 and 3 agree
    s_d.m_s1 = modem_pins;
    s_d.m_s2 = s_q.m_s1;
    s_d.m_s3 = s_q.m_s2;
    m_new    = s_q.m_st;
    for (int i = 0; i < 4; i++) begin
      if (s_q.m_s2[i] == s_q.m_s3[i]) begin
        m_new[i] = s_q.m_s3[i];
      end
    end
    s_d.m_st  = m_new;
    modem_chg = m_new != s_q.m_st;
    s_d.m_dlt = (rd_msr ? 4'h0 : s_q.m_dlt) | (m_new ^ s_q.m_st);

    fc_rise = (s_q.auto_cts && !s_q.m_st[0] && m_new[0])
              || (s_q.auto_rts && !s_q.rts_prev && rts_n);
    s_d.rts_prev = rts_n;

    if (wr_ier) begin
      s_d.ier = reg_req.wdata;
    end
    if (wr_feat) begin
      s_d.mode256  = reg_req.wdata[`FEAT_256];
      s_d.enh_en   = reg_req.wdata[`FEAT_ENH];
      s_d.auto_rts = reg_req.wdata[`FEAT_ARTS];
      s_d.auto_cts = reg_req.wdata[`FEAT_ACTS];
    end
    if (wr_fcr) begin
      s_d.fifo_en  = reg_req.wdata[`FCR_EN];
      s_d.dma_mode = reg_req.wdata[`FCR_DMA];
      s_d.rx_sel   = reg_req.wdata[7:6];
      if (s_q.enh_en) begin
        s_d.tx_sel = reg_req.wdata[5:4];
      end
    end

    if (rx_empty || rx_push || rd_data || !s_q.fifo_en) begin
      s_d.to_cnt = 3'h0;
    end else if (char_tick && s_q.to_cnt != `CHAR_TIMEOUT) begin
      s_d.to_cnt = s_q.to_cnt + 3'h1;
    end
    s_d.cti = (s_q.cti && !rd_data)
              || (char_tick && !rx_empty && !rx_push && !rd_data && s_q.fifo_en
                  && s_q.to_cnt == `CHAR_TIMEOUT - 3'h1);

    s_d.rls = (s_q.rls && !rd_lsr) || lsr_err_event;

    s_d.tx_above = tx_above_now;
    s_d.tx_busy  = !tx_empty;
    s_d.thre     = (s_q.thre && !wr_data && !(rd_isr && code == `CODE_THRE)) || thre_evt;

    s_d.msi = (s_q.msi && !rd_msr) || modem_chg;

    s_d.xoff = (s_q.xoff && !(rd_isr && code == `CODE_XOFF)) || xoff_event;

    s_d.fcev = (s_q.fcev && !(rd_isr && code == `CODE_FC)) || fc_rise;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q      <= '0;
      s_q.ier  <= `IER_RST;
      // pins idle high, so no false change after reset
      s_q.m_s1 <= 4'hF;
      s_q.m_s2 <= 4'hF;
      s_q.m_s3 <= 4'hF;
      s_q.m_st <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign dma_mode  = s_q.dma_mode;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_isr_rd;
    reg_req.rd && reg_req.addr == `OFS_ISR_FCR;
  endsequence

  property p_rls_top;
    s_isr_rd and pend[0] |=> reg_rdata[5:0] == `CODE_RLS;
  endproperty
  a_rls_top: assert property (p_rls_top) else $error("line status not on top");

  property p_rda_code;
    s_q.fifo_en && rx_cnt >= rx_trig && s_q.ier[`IER_RDA] && !pend[0]
      |-> code == `CODE_RDA;
  endproperty
  a_rda_code: assert property (p_rda_code) else $error("data available code wrong");

  property p_cti_cause;
    $rose(s_q.cti) |-> $past(s_q.to_cnt) == 3'h3 && $past(char_tick);
  endproperty
  a_cti_cause: assert property (p_cti_cause) else $error("timeout set too early");

  property p_thre_clr;
    wr_data && !thre_evt |=> !s_q.thre;
  endproperty
  a_thre_clr: assert property (p_thre_clr) else $error("holding empty not cleared");

  property p_msi_clr;
    rd_msr && !modem_chg |=> !s_q.msi;
  endproperty
  a_msi_clr: assert property (p_msi_clr) else $error("modem flag not cleared");

  property p_xoff_clr;
    s_isr_rd and (code == `CODE_XOFF && !xoff_event) |=> !s_q.xoff;
  endproperty
  a_xoff_clr: assert property (p_xoff_clr) else $error("xoff flag not cleared");

  property p_tx_full_bit;
    s_isr_rd and s_q.mode256 |=> reg_rdata[7] == !$past(tx_full);
  endproperty
  a_tx_full_bit: assert property (p_tx_full_bit) else $error("tx full bit wrong");

  property p_rx_full_bit;
    s_isr_rd and s_q.mode256 |=> reg_rdata[6] == $past(rx_full);
  endproperty
  a_rx_full_bit: assert property (p_rx_full_bit) else $error("rx full bit wrong");

  property p_tx_trig_lock;
    wr_fcr && !s_q.enh_en |=> $stable(s_q.tx_sel);
  endproperty
  a_tx_trig_lock: assert property (p_tx_trig_lock) else $error("tx trigger changed");

  property p_tx_reset;
    tx_clr |=> tx_cnt == '0 ##1 !s_q.tx_busy;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx fifo not reset");

  property p_irq_code;
    s_isr_rd and irq |=> reg_rdata[5:0] != `CODE_NONE;
  endproperty
  a_irq_code: assert property (p_irq_code) else $error("irq without code");

  property p_rx_reset;
    rx_clr |=> rx_cnt == '0;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("rx fifo not reset");

  property p_fc_code;
    s_isr_rd and (pend[6] && pend[5:0] == '0) |=> reg_rdata[5:0] == `CODE_FC;
  endproperty
  a_fc_code: assert property (p_fc_code) else $error("flow control code wrong");

  property p_msi_set;
    modem_chg |=> s_q.msi;
  endproperty
  a_msi_set: assert property (p_msi_set) else $error("modem change not flagged");

  property p_fifo_off_one;
    !s_q.fifo_en |-> rx_cnt <= CW'(1) && tx_cnt <= CW'(1);
  endproperty
  a_fifo_off_one: assert property (p_fifo_off_one) else $error("more than one entry");

  property p_dma_sel;
    wr_fcr |=> dma_mode == $past(reg_req.wdata[`FCR_DMA]);
  endproperty
  a_dma_sel: assert property (p_dma_sel) else $error("dma mode not taken");
endmodule
`default_nettype wire

/* File: tb/uart_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_far_side
  import uart_ctrl_pkg::*;
(
  input  wire logic                 mclk,
  output logic                      rx_push,
  output logic [7:0]                rx_data,
  output logic                      lsr_err_event,
  output logic                      xoff_event,
  output logic                      char_tick,
  output uart_ctrl_pkg::modem_pins_t modem_pins,
  output logic                      rts_n,
  output logic                      tx_pop
);
  // ----------------------------------------
  // shifter and modem side stimulus
  // ----------------------------------------
  initial begin
    rx_push       = 1'b0;
    rx_data       = 8'h00;
    lsr_err_event = 1'b0;
    xoff_event    = 1'b0;
    char_tick     = 1'b0;
    modem_pins    = 4'hF;
    rts_n         = 1'b0;
    tx_pop        = 1'b0;
  end

  // received byte, data line inverted once released
  task automatic push_rx(input logic [7:0] d);
    @(posedge mclk);
    rx_push <= 1'b1;
    rx_data <= d;
    @(posedge mclk);
    rx_push <= 1'b0;
    rx_data <= ~d;
  endtask

  // one-cycle event: 0 error, 1 xoff, 2 char time, 3 take tx byte
  task automatic pulse(input int which);
    @(posedge mclk);
    case (which)
      0: lsr_err_event <= 1'b1;
      1: xoff_event <= 1'b1;
      2: char_tick <= 1'b1;
      default: tx_pop <= 1'b1;
    endcase
    @(posedge mclk);
    {lsr_err_event, xoff_event, char_tick, tx_pop} <= 4'h0;
  endtask

  task automatic set_pins(input logic [3:0] p);
    @(posedge mclk);
    modem_pins <= p;
  endtask

  task automatic set_rts(input logic v);
    @(posedge mclk);
    rts_n <= v;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_uart_irq_priority_fifo_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctrl_regs.svh"
module test_uart_irq_priority_fifo_ctrl;
  import uart_ctrl_pkg::*;
  logic        mclk;
  logic        rst_n;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata;
  logic        rx_push;
  logic [7:0]  rx_data;
  logic        lsr_err_event;
  logic        xoff_event;
  logic        char_tick;
  modem_pins_t modem_pins;
  logic        rts_n;
  logic        tx_pop;
  logic [7:0]  tx_data;
  logic        tx_empty;
  logic        dma_mode;
  logic        irq;
  logic [7:0]  d;
  logic [3:0]  pins;
  logic [7:0]  lsr_val;
  int          n_mismatch;
  int          samples_checked;
  int          trig [4] = '{8, 16, 56, 60};

  uart_irq_priority_fifo_ctrl dut (
    .mclk(mclk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .rx_push(rx_push), .rx_data(rx_data), .lsr_err_event(lsr_err_event),
    .line_status_reg(lsr_val), .xoff_event(xoff_event), .char_tick(char_tick),
    .modem_pins(modem_pins), .rts_n(rts_n), .tx_pop(tx_pop), .tx_data(tx_data),
    .tx_empty(tx_empty), .dma_mode(dma_mode), .irq(irq)
  );

  uart_far_side far (
    .mclk(mclk), .rx_push(rx_push), .rx_data(rx_data), .lsr_err_event(lsr_err_event),
    .xoff_event(xoff_event), .char_tick(char_tick), .modem_pins(modem_pins),
    .rts_n(rts_n), .tx_pop(tx_pop)
  );

  // ----------------------------------------
  // clock, checks and register access
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    reg_req <= '0;
    #1 v = reg_rdata;
    @(posedge mclk);
    #1 chk("rdata idle", 8'h00, reg_rdata);
  endtask

  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
    rd(a, d);
    chk(what, exp, d);
  endtask

  // irq level first, then the source register (reading may clear)
  task automatic interrupt_source_status(input logic [7:0] exp);
    @(posedge mclk);
    #1 chk("irq", {7'h00, exp[5:0] != `CODE_NONE}, {7'h00, irq});
    rchk("isr", `OFS_ISR_FCR, exp);
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    lsr_val = 8'h00;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk("dma", 8'h00, {7'h00, dma_mode});
    chk("tx empty", 8'h01, {7'h00, tx_empty});
    rd(`OFS_MSR, d);
    interrupt_source_status(8'h01);
    wr(`OFS_IER, 8'hEF);
    wr(`OFS_ISR_FCR, 8'h01);
    interrupt_source_status(8'hC1);
    // rx trigger levels; tx field written but must be ignored
    for (int s = 0; s < 4; s++) begin
      wr(`OFS_ISR_FCR, {s[1:0], 2'b11, s[0], 3'b011});
      #1 chk("dma", {7'h00, s[0]}, {7'h00, dma_mode});
      rchk("rx count", `OFS_RXCNT, 8'h00);
      for (int i = 0; i < trig[s] - 1; i++) far.push_rx(i[7:0]);
      interrupt_source_status(8'hC1);
      far.push_rx(8'h5A);
      interrupt_source_status(8'hC4);
    end
    wr(`OFS_ISR_FCR, 8'h03);
    for (int i = 0; i < 8; i++) far.push_rx(i[7:0]);
    far.pulse(0);
    interrupt_source_status(8'hC6);
    @(posedge mclk) lsr_val <= 8'h9E;
    rchk("lsr", `OFS_LSR, 8'h9E);
    interrupt_source_status(8'hC4);
    rchk("rx byte", `OFS_DATA, 8'h00);
    interrupt_source_status(8'hC1);
    for (int i = 0; i < 3; i++) far.pulse(2);
    @(posedge mclk);
    #1 chk("irq", 8'h00, {7'h00, irq});
    far.pulse(2);
    interrupt_source_status(8'hCC);
    rchk("rx byte", `OFS_DATA, 8'h01);
    interrupt_source_status(8'hC1);
    wr(`OFS_ISR_FCR, 8'h03);
    // tx trigger 8 still active since the field was locked
    for (int i = 0; i < 9; i++) wr(`OFS_DATA, i[7:0]);
    #1 chk("tx data", 8'h00, tx_data);
    far.pulse(3);
    interrupt_source_status(8'hC2);
    chk("tx data", 8'h01, tx_data);
    interrupt_source_status(8'hC1);
    wr(`OFS_FEAT, 8'h10);
    wr(`OFS_ISR_FCR, 8'h25);
    rchk("tx count", `OFS_TXCNT, 8'h00);
    chk("tx empty", 8'h01, {7'h00, tx_empty});
    for (int i = 0; i < 33; i++) wr(`OFS_DATA, i[7:0]);
    far.pulse(3);
    interrupt_source_status(8'hC2);
    wr(`OFS_DATA, 8'hA5);
    interrupt_source_status(8'hC1);
    // modem pin changes, one at a time
    pins = 4'hF;
    for (int k = 0; k < 4; k++) begin
      pins = pins ^ 4'(1 << k);
      far.set_pins(pins);
      repeat (6) @(posedge mclk);
      interrupt_source_status(8'hC0);
      rchk("modem", `OFS_MSR, {~pins, 4'(1 << k)});
      interrupt_source_status(8'hC1);
    end
    wr(`OFS_FEAT, 8'h90);
    far.set_pins(4'h1);
    repeat (6) @(posedge mclk);
    rd(`OFS_MSR, d);
    interrupt_source_status(8'hE0);
    interrupt_source_status(8'hC1);
    wr(`OFS_FEAT, 8'hD0);
    far.set_rts(1'b1);
    interrupt_source_status(8'hE0);
    interrupt_source_status(8'hC1);
    far.pulse(1);
    interrupt_source_status(8'hD0);
    interrupt_source_status(8'hC1);
    wr(`OFS_IER, 8'h00);
    far.pulse(0);
    @(posedge mclk);
    #1 chk("irq", 8'h00, {7'h00, irq});
    rchk("isr", `OFS_ISR_FCR, 8'hC1);
    wr(`OFS_IER, 8'hEF);
    interrupt_source_status(8'hC6);
    rd(`OFS_LSR, d);
    // large buffers: full and empty share a zero count
    wr(`OFS_FEAT, 8'h11);
    rd(`OFS_ISR_FCR, d);
    interrupt_source_status(8'h81);
    for (int i = 0; i < 256; i++) wr(`OFS_DATA, i[7:0]);
    rchk("tx count", `OFS_TXCNT, 8'h00);
    chk("tx empty", 8'h00, {7'h00, tx_empty});
    interrupt_source_status(8'h01);
    for (int i = 0; i < 257; i++) far.push_rx(i[7:0]);
    rchk("rx count", `OFS_RXCNT, 8'h00);
    interrupt_source_status(8'h44);
    // fifos off: one character held in entry zero
    wr(`OFS_ISR_FCR, 8'h00);
    far.push_rx(8'h3C);
    far.push_rx(8'h77);
    rchk("rx count", `OFS_RXCNT, 8'h01);
    rchk("rx byte", `OFS_DATA, 8'h3C);
    close_out();
  end
endmodule
`default_nettype wire
